// ---- salu_top.sv ----
`timescale 1ns/1ps
// What this block does
// - sub memory command: accumulator minus memory into accumulator
// - to-memory command: difference written back to memory
// - carry cleared on borrow, set otherwise
// - immediate command subtracts operand into accumulator
`include "salu_cfg.svh"

module salu_top
   import salu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [7:0]  accumulatorOut,
   output logic      [7:0]  statusOut
);

   // ----------------------------------------------------------------------
   // state and datapath signals
   // ----------------------------------------------------------------------
   salu_state_s st_ff;
   salu_state_s nxt_st;

   salu_op_e    opcode;
   logic [7:0]  operand;
   logic [3:0]  memIdx;
   logic [7:0]  opB;
   logic [8:0]  diffWide;
   logic [4:0]  nibWide;
   logic [7:0]  result;
   logic [7:0]  newStatus;
   logic        isMemWin;
   logic [3:0]  winIdx;
   logic [31:0] readMux;
   logic [7:0]  wordAddr;
   logic        selAcc;
   logic        selStatus;
   logic        selCmd;
   logic        accSign;
   logic        opSign;
   logic        resSign;
   logic        borrowOut;
   logic        halfBorrow;
   logic        zeroRes;
   logic        ovfRes;
   logic        wrCommit;
   logic        cmdCommit;
   logic [`SALU_MEM_DEPTH-1:0] hostWe;
   logic [`SALU_MEM_DEPTH-1:0] subWe;

   // ----------------------------------------------------------------------
   // subtractor
   // ----------------------------------------------------------------------
   always_comb begin
      opcode   = salu_op_e'(avs_writedata[`SALU_CMD_OP_MSB:`SALU_CMD_OP_LSB]);
      operand  = avs_writedata[`SALU_CMD_OPND_MSB:`SALU_CMD_OPND_LSB];
      // memory operand is indexed by the low operand bits only, so it aliases
      memIdx   = operand[3:0];
      opB      = (opcode == SALU_OP_SUB_IMM) ? operand : st_ff.mem[memIdx];
      diffWide = {1'b0, st_ff.acc} - {1'b0, opB};
      nibWide  = {1'b0, st_ff.acc[3:0]} - {1'b0, opB[3:0]};
      result   = diffWide[7:0];
      accSign    = st_ff.acc[7];
      opSign     = opB[7];
      resSign    = result[7];
      // nine-bit difference keeps the borrow in its top bit
      borrowOut  = diffWide[8];
      halfBorrow = nibWide[4];
      zeroRes    = (result == 8'h00);
      ovfRes     = (accSign != opSign) && (resSign != accSign);
      // carry and aux carry are inverted borrows, as the core expects
      // upper status bits belong to the rest of the core and pass through
      newStatus                 = st_ff.status;
      newStatus[`SALU_ST_CARRY] = ~borrowOut;
      newStatus[`SALU_ST_AUX]   = ~halfBorrow;
      newStatus[`SALU_ST_ZERO]  = zeroRes;
      newStatus[`SALU_ST_OVF]   = ovfRes;
   end

   // ----------------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------------
   always_comb begin
      isMemWin = (avs_address[7:6] == `SALU_MEM_BASE_HI);
      winIdx   = avs_address[5:2];
      wordAddr  = {avs_address[7:2], 2'b00};
      selAcc    = !isMemWin && (wordAddr == `SALU_OFS_ACC);
      selStatus = !isMemWin && (wordAddr == `SALU_OFS_STATUS);
      selCmd    = !isMemWin && (wordAddr == `SALU_OFS_CMD);
      readMux  = 32'h0000_0000;
      if (isMemWin) begin
         readMux = {24'h00_0000, st_ff.mem[winIdx]};
      end else begin
         if (selAcc) begin
            readMux = {24'h00_0000, st_ff.acc};
         end else if (selStatus) begin
            readMux = {24'h00_0000, st_ff.status};
         end else if (selCmd) begin
            readMux = {16'h0000, st_ff.cmd};
         end
      end
   end

   // ----------------------------------------------------------------------
   // write strobes
   // ----------------------------------------------------------------------
   // a write lands only on the completing edge, while the slave shows ACK
   assign wrCommit  = (st_ff.bus == SALU_BUS_ACK) && avs_write && avs_byteenable[0];
   assign cmdCommit = wrCommit && selCmd;

   // host and command strobes are exclusive: one needs the window, one the command word
   for (genvar g = 0; g < `SALU_MEM_DEPTH; g++) begin : gen_memWe
      assign hostWe[g] = wrCommit && isMemWin && (winIdx == 4'(g));
      assign subWe[g]  = cmdCommit && (opcode == SALU_OP_SUB_MEM) && (memIdx == 4'(g));
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.bus)
         SALU_BUS_IDLE: begin
            // one wait cycle keeps the read mux off the path to readdata
            if (avs_read || avs_write) begin
               nxt_st.bus     = SALU_BUS_ACK;
               nxt_st.waitReq = 1'b0;
               nxt_st.rdata   = avs_read ? readMux : 32'h0000_0000;
            end
         end
         SALU_BUS_ACK: begin
            nxt_st.bus     = SALU_BUS_IDLE;
            nxt_st.waitReq = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
               if (isMemWin) begin
                  for (int i = 0; i < `SALU_MEM_DEPTH; i++) begin
                     if (hostWe[i]) begin
                        nxt_st.mem[i] = avs_writedata[7:0];
                     end
                  end
               end else begin
                  case ({avs_address[7:2], 2'b00})
                     `SALU_OFS_ACC:    nxt_st.acc    = avs_writedata[7:0];
                     `SALU_OFS_STATUS: nxt_st.status = avs_writedata[7:0];
                     `SALU_OFS_CMD: begin
                        nxt_st.cmd = avs_writedata[15:0];
                        case (opcode)
                           SALU_OP_SUB_ACC: begin
                              nxt_st.acc    = result;
                              nxt_st.status = newStatus;
                           end
                           SALU_OP_SUB_MEM: begin
                              for (int i = 0; i < `SALU_MEM_DEPTH; i++) begin
                                 if (subWe[i]) begin
                                    nxt_st.mem[i] = result;
                                 end
                              end
                              nxt_st.status = newStatus;
                           end
                           SALU_OP_SUB_IMM: begin
                              nxt_st.acc    = result;
                              nxt_st.status = newStatus;
                           end
                           default: begin
                              nxt_st.acc = st_ff.acc;
                           end
                        endcase
                     end
                     default: begin
                        nxt_st.acc = st_ff.acc;
                     end
                  endcase
               end
            end
         end
         default: begin
            nxt_st.bus     = SALU_BUS_IDLE;
            nxt_st.waitReq = 1'b1;
         end
      endcase
      if (reset) begin
         nxt_st.bus     = SALU_BUS_IDLE;
         nxt_st.waitReq = 1'b1;
         nxt_st.rdata   = 32'h0000_0000;
         nxt_st.acc     = `SALU_RST_ACC;
         nxt_st.status  = `SALU_RST_STATUS;
         nxt_st.cmd     = `SALU_RST_CMD;
         nxt_st.mem     = '0;
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      st_ff <= nxt_st;
   end

   // ----------------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------------
   assign avs_readdata    = st_ff.rdata;
   assign avs_waitrequest = st_ff.waitReq;
   assign accumulatorOut  = st_ff.acc;
   assign statusOut       = st_ff.status;

endmodule : salu_top

// ---- salu_cfg.svh ----
`ifndef SALU_CFG_SVH
`define SALU_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SALU_OFS_ACC      8'h00
`define SALU_OFS_STATUS   8'h04
`define SALU_OFS_CMD      8'h08
`define SALU_MEM_BASE_HI  2'h1
`define SALU_MEM_DEPTH    16

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SALU_ST_CARRY     0
`define SALU_ST_AUX       1
`define SALU_ST_ZERO      2
`define SALU_ST_OVF       3
`define SALU_CMD_OP_LSB   0
`define SALU_CMD_OP_MSB   1
`define SALU_CMD_OPND_LSB 8
`define SALU_CMD_OPND_MSB 15

// ----------------------------------------------------------------------
// command codes and reset values
// ----------------------------------------------------------------------
`define SALU_OPC_SUB_ACC  2'h1
`define SALU_OPC_SUB_MEM  2'h2
`define SALU_OPC_SUB_IMM  2'h3
`define SALU_RST_ACC      8'h00
`define SALU_RST_STATUS   8'h00
`define SALU_RST_CMD      16'h0000

`endif

// ---- salu_pkg.sv ----
`include "salu_cfg.svh"

package salu_pkg;

   typedef enum logic [1:0] {
      SALU_OP_NONE    = 2'h0,
      SALU_OP_SUB_ACC = `SALU_OPC_SUB_ACC,
      SALU_OP_SUB_MEM = `SALU_OPC_SUB_MEM,
      SALU_OP_SUB_IMM = `SALU_OPC_SUB_IMM
   } salu_op_e;

   typedef enum logic [1:0] {
      SALU_BUS_IDLE = 2'b01,
      SALU_BUS_ACK  = 2'b10
   } salu_bus_e;

   typedef struct packed {
      salu_bus_e                            bus;
      logic                                 waitReq;
      logic [31:0]                          rdata;
      logic [7:0]                           acc;
      logic [7:0]                           status;
      logic [15:0]                          cmd;
      logic [`SALU_MEM_DEPTH-1:0][7:0]      mem;
   } salu_state_s;

endpackage : salu_pkg

// ---- salu_props.sv ----
`timescale 1ns/1ps
module salu_props (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  accumulatorOut,
   input wire logic [7:0]  statusOut
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire       cmdDone = avs_write & !avs_waitrequest & avs_address == 8'h08 & avs_byteenable[0];
   wire [1:0] op      = avs_writedata[1:0];
   wire [7:0] opnd    = avs_writedata[15:8];
   chk_imm_result:
   assert property (cmdDone && op == 2'h3 |=> accumulatorOut == $past(accumulatorOut) - $past(opnd))
      else $error("immediate difference wrong");
   chk_imm_carry:
   assert property (cmdDone && op == 2'h3 |=> statusOut[0] == ($past(accumulatorOut) >= $past(opnd)))
      else $error("carry wrong after immediate");
   chk_zero_flag:
   assert property (cmdDone && op[0] |=> statusOut[2] == (accumulatorOut == 8'h00))
      else $error("zero flag wrong");
   chk_upper_kept:
   assert property (cmdDone && op != 2'h0 |=> $stable(statusOut[7:4]))
      else $error("upper status bits changed");
   chk_mem_acc_kept:
   assert property (cmdDone && op == 2'h2 |=> $stable(accumulatorOut))
      else $error("accumulator changed by memory destination");
endmodule : salu_props

// ---- subtract_instruction_alu_tb.sv ----
`timescale 1ns/1ps
module subtract_instruction_alu_tb;
   import salu_pkg::*;
   logic        mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic        avs_waitrequest;
   logic [7:0]  avs_address = 8'h00, accumulatorOut, statusOut, acc = 8'h00, st, d, r;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'hC9FD6964;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [7:0]  mem [16] = '{default: 8'h00};
   logic [31:0] expQ [$];
   int          fails = 0, comparisons = 0, cycles = 0;
   always #5 mclk = ~mclk;
   salu_top dut (.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
                 .avs_byteenable, .avs_readdata, .avs_waitrequest, .accumulatorOut, .statusOut);
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic complete_run;
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // ---------------------------------------------------------------
   // bus master: request held until waitrequest seen low at an edge
   // ---------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dt,
                      input logic [31:0] e);
      avs_address <= a;
      avs_writedata <= dt;
      avs_write <= wr;
      avs_read <= !wr;
      if (!wr) expQ.push_back(e);
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // extra edge keeps the next request off the release time step
      @(posedge mclk);
   endtask : bus
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
      if (avs_read && avs_waitrequest === 1'b0) begin
         comparisons++;
         if (avs_readdata !== expQ[0]) begin
            fails++;
            $display("unexpected readdata @%h: expected %h seen %h", avs_address, expQ[0],
                     avs_readdata);
         end
         void'(expQ.pop_front());
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      bus(0, 8'h00, 0, 0);
      bus(0, 8'h30, 0, 0);
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         mem[i] = rnd[7:0];
         bus(1, 8'h40 + 8'(4 * i), {24'h0, rnd[7:0]}, 0);
      end
      avs_byteenable <= 4'hE;
      bus(1, 8'h00, 32'h55, 0);
      avs_byteenable <= 4'hF;
      bus(0, 8'h00, 0, 0);
      for (int k = 0; k < 80; k++) begin
         rnd = lfsr(rnd);
         if (k % 8 == 0) rnd[15:8] = acc;
         st = rnd[23:16];
         bus(1, 8'h04, {24'h0, st}, 0);
         d = rnd[1:0] == 2'h3 ? rnd[15:8] : mem[rnd[11:8]];
         r = acc - d;
         if (rnd[1:0] != 2'h0)
            st = {st[7:4], (acc[7] != d[7]) && (r[7] != acc[7]), r == 8'h00,
                  acc[3:0] >= d[3:0], acc >= d};
         bus(1, 8'h08, {16'h0, rnd[15:0]}, 0);
         if (rnd[1:0] == 2'h2) mem[rnd[11:8]] = r;
         else if (rnd[1:0] != 2'h0) acc = r;
         bus(0, 8'h00, 0, {24'h0, acc});
         bus(0, 8'h04, 0, {24'h0, st});
         bus(0, 8'h40 + {rnd[11:8], 2'b00}, 0, {24'h0, mem[rnd[11:8]]});
      end
      complete_run();
   end
endmodule : subtract_instruction_alu_tb
bind salu_top salu_props chk (.mclk, .reset, .avs_address, .avs_write, .avs_writedata,
                              .avs_byteenable, .avs_waitrequest, .accumulatorOut, .statusOut);
